// File: core/ebseq_core.sv
/*
  external bus cycle phase sequencer: runs each bus cycle through up to five
  phases with lengths taken from the chip-select timing control inputs, and
  stretches the access phase with the ready handshake.
  assumes start is held until start_ack, and timing inputs are stable during
  a cycle; ready is synchronous to ref_clk unless ready_async is set.
*/
// Function
// - every cycle runs address setup, command delay, write setup, access, hold in order, skipping zero-length phases
// - each phase length is taken from chip-select timing control inputs
// - ready option lets the external module stretch the access phase
// - address setup lasts 1 or 2 units, up to 5 with window extension
// - changed address window adds 0 to 3 extra setup units
// - write setup or mux tristate phase lasts 0 or 1 unit
// - access phase lasts 1 to 32 units before ready extension
// - address and write data hold phase lasts 0 to 3 units
// - reference clock output follows system clock when selected and driver enabled
// - ready sampled inactive inserts a wait state, active ends the wait and moves on to hold, or to idle when hold is 0
// - asynchronous ready passes an extra stage costing at least one wait state
`timescale 1ns/1ps
module ebseq_core (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        window_changed,
  input  wire logic [3:0]  unit_div,
  input  wire logic        setup_base,
  input  wire logic [1:0]  setup_ext,
  input  wire logic [1:0]  cmd_delay,
  input  wire logic        wr_setup,
  input  wire logic [4:0]  access_len,
  input  wire logic [1:0]  hold_len,
  input  wire logic        ready_en,
  input  wire logic        ready_async,
  input  wire logic        ready_active_low,
  input  wire logic        ready_in,
  input  wire logic        bus_reference_clock_sel_sys,
  input  wire logic        bus_reference_clock_hs_en,
  output logic             start_ack,
  output logic             busy,
  output logic [2:0]       phase,
  output logic             cycle_done,
  output logic             bus_reference_clock,
  output logic             bus_reference_clock_oe
);
  ebseq_pkg::ebseq_phase_t state_r;
  ebseq_pkg::ebseq_phase_t state_nxt;
  logic [ebseq_pkg::PHASE_CNT_W-1:0] left_r;
  logic [ebseq_pkg::PHASE_CNT_W-1:0] left_nxt;
  logic [1:0]  waits_r;
  logic        rdy_s1_r;
  logic        rdy_s2_r;
  logic        done_r;
  logic        tick;
  logic        rdy_raw;
  logic        rdy_seen;
  logic [2:0]  setup_units;
  logic        restart;

  assign restart = (state_r == ebseq_pkg::IDLE) && start;

  ebseq_unit_tick u_tick (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .restart  (restart),
    .unit_div (unit_div),
    .tick     (tick)
  );

  // setup = base (1 or 2) plus window extension (0..3), at most 5
  assign setup_units = 3'(setup_base) + 3'h1 + (window_changed ? 3'(setup_ext) : 3'h0);

  // ready polarity is selectable; input treated as synchronous otherwise
  assign rdy_raw = ready_in ^ ready_active_low;

  // two flops for async ready; only the second stage is observed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end else if (clk_en) begin
      rdy_s1_r <= rdy_raw;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // async path adds its sync stage; synchronous ready is used directly
  assign rdy_seen = ready_async ? rdy_s2_r : rdy_raw;

  // phase sequencing; a zero-length phase is skipped in the same step
  always_comb begin
    state_nxt = state_r;
    left_nxt  = left_r;
    case (state_r)
      ebseq_pkg::IDLE: begin
        if (start) begin
          state_nxt = ebseq_pkg::ADDR_SETUP;
          left_nxt  = 5'(setup_units - 3'h1);
        end
      end
      ebseq_pkg::ADDR_SETUP: begin
        if (tick) begin
          if (left_r != '0) begin
            left_nxt = left_r - 1'b1;
          end else if (cmd_delay != 2'h0) begin
            state_nxt = ebseq_pkg::CMD_DELAY;
            left_nxt  = 5'(cmd_delay) - 5'h01;
          end else if (wr_setup) begin
            state_nxt = ebseq_pkg::WR_SETUP;
            left_nxt  = 5'h00;
          end else begin
            state_nxt = ebseq_pkg::ACCESS;
            left_nxt  = access_len;
          end
        end
      end
      ebseq_pkg::CMD_DELAY: begin
        if (tick) begin
          if (left_r != '0) begin
            left_nxt = left_r - 1'b1;
          end else if (wr_setup) begin
            state_nxt = ebseq_pkg::WR_SETUP;
            left_nxt  = 5'h00;
          end else begin
            state_nxt = ebseq_pkg::ACCESS;
            left_nxt  = access_len;
          end
        end
      end
      ebseq_pkg::WR_SETUP: begin
        if (tick) begin
          state_nxt = ebseq_pkg::ACCESS;
          left_nxt  = access_len;
        end
      end
      ebseq_pkg::ACCESS: begin
        if (tick) begin
          if (left_r != '0) begin
            left_nxt = left_r - 1'b1;
          end else if (ready_en) begin
            state_nxt = ebseq_pkg::READY_WAIT;
          end else if (hold_len != 2'h0) begin
            state_nxt = ebseq_pkg::HOLD;
            left_nxt  = 5'(hold_len) - 5'h01;
          end else begin
            state_nxt = ebseq_pkg::IDLE;
          end
        end
      end
      ebseq_pkg::READY_WAIT: begin
        // sample point at unit end; async also waits out its mandatory stage
        if (tick && rdy_seen && waits_r == 2'h0) begin
          if (hold_len != 2'h0) begin
            state_nxt = ebseq_pkg::HOLD;
            left_nxt  = 5'(hold_len) - 5'h01;
          end else begin
            state_nxt = ebseq_pkg::IDLE;
          end
        end
      end
      ebseq_pkg::HOLD: begin
        if (tick) begin
          if (left_r != '0) begin
            left_nxt = left_r - 1'b1;
          end else begin
            state_nxt = ebseq_pkg::IDLE;
          end
        end
      end
      default: begin
        state_nxt = ebseq_pkg::IDLE;
      end
    endcase
  end

  // phase state and remaining units
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ebseq_pkg::IDLE;
      left_r  <= '0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      left_r  <= left_nxt;
    end
  end

  // async ready costs at least one wait state before sampling counts
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waits_r <= 2'h0;
    end else if (clk_en) begin
      if (state_r != ebseq_pkg::READY_WAIT && state_nxt == ebseq_pkg::READY_WAIT) begin
        waits_r <= ready_async ? ebseq_pkg::MANDATORY_WAITS : 2'h0;
      end else if (state_r == ebseq_pkg::READY_WAIT && tick && waits_r != 2'h0) begin
        waits_r <= waits_r - 2'h1;
      end
    end
  end

  // one-cycle completion pulse when a cycle returns to idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= (state_r != ebseq_pkg::IDLE) && (state_nxt == ebseq_pkg::IDLE);
    end
  end

  assign start_ack  = restart && clk_en;
  assign busy       = (state_r != ebseq_pkg::IDLE);
  assign phase      = state_r;
  assign cycle_done = done_r;

  // reference clock is the system clock itself, gated by select and driver
  assign bus_reference_clock    = ref_clk & bus_reference_clock_sel_sys & bus_reference_clock_hs_en;
  assign bus_reference_clock_oe = bus_reference_clock_sel_sys & bus_reference_clock_hs_en;
endmodule

// File: include/ebseq_pkg.sv
/*
  package for the external bus cycle phase sequencer: phase states, field
  widths, reset values and timing-unit counts.
  assumes a single 100 MHz system clock feeding all users of the package.
*/
package ebseq_pkg;
  typedef enum logic [2:0] {
    IDLE,
    ADDR_SETUP,
    CMD_DELAY,
    WR_SETUP,
    ACCESS,
    READY_WAIT,
    HOLD
  } ebseq_phase_t;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned UNIT_CNT_W      = 4;    // width of time-unit prescaler
  localparam int unsigned PHASE_CNT_W     = 5;    // width of phase length counter
  localparam logic [3:0]  UNIT_DIV_RST    = 4'h0; // one sys clock per unit at reset
  localparam logic [0:0]  SETUP_BASE_RST  = 1'h0; // 1 unit
  localparam logic [1:0]  SETUP_EXT_RST   = 2'h0;
  localparam logic [1:0]  CMD_DELAY_RST   = 2'h0;
  localparam logic [0:0]  WR_SETUP_RST    = 1'h0;
  localparam logic [4:0]  ACCESS_RST      = 5'h00; // encodes 1 unit
  localparam logic [1:0]  HOLD_RST        = 2'h0;
  localparam logic [1:0]  MANDATORY_WAITS = 2'h1; // async ready sync stage penalty
endpackage

// File: core/ebseq_unit_tick.sv
/*
  chip-select time unit prescaler: emits one-cycle tick every div+1 clocks.
  assumes restart pulses at the start of each bus cycle to align units.
*/
`timescale 1ns/1ps
module ebseq_unit_tick (
  input  wire logic                                ref_clk,
  input  wire logic                                rstn,
  input  wire logic                                clk_en,
  input  wire logic                                restart,
  input  wire logic [ebseq_pkg::UNIT_CNT_W-1:0]    unit_div,
  output logic                                     tick
);
  logic [ebseq_pkg::UNIT_CNT_W-1:0] cnt_r;

  // counts down; tick when reaching zero, reload from divider
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= ebseq_pkg::UNIT_DIV_RST;
    end else if (clk_en) begin
      if (restart || cnt_r == '0) begin
        cnt_r <= unit_div;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign tick = clk_en && !restart && (cnt_r == '0);
endmodule

// File: test/ebseq_monitor.sv
/* checker for the bus cycle sequencer ports.
   assumes it is bound to ebseq_core, one clock domain. */
`timescale 1ns/1ps
module ebseq_monitor (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic       start,
  input wire logic [3:0] unit_div,
  input wire logic       setup_base,
  input wire logic [1:0] cmd_delay,
  input wire logic       wr_setup,
  input wire logic [4:0] access_len,
  input wire logic [1:0] hold_len,
  input wire logic       ready_en,
  input wire logic       ready_async,
  input wire logic       ready_active_low,
  input wire logic       ready_in,
  input wire logic       bus_reference_clock_sel_sys,
  input wire logic       bus_reference_clock_hs_en,
  input wire logic       start_ack,
  input wire logic       busy,
  input wire logic [2:0] phase,
  input wire logic       cycle_done,
  input wire logic       bus_reference_clock_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // phases only move forward, back to idle from access onwards
  property p_order;
    phase != $past(phase) |-> (phase > $past(phase) || (phase == 3'h0 && $past(phase) >= 3'h4))
      && ($past(phase) != 3'h0 || phase == 3'h1);
  endproperty
  a_order: assert property (p_order) else $error("illegal phase step");
  property p_ack; start_ack == (start && clk_en && phase == 3'h0); endproperty
  a_ack: assert property (p_ack) else $error("start taken outside idle");
  // done rises on the same edge that returns the state to idle
  property p_done; $fell(busy) |-> cycle_done ##1 !cycle_done; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_setup2; start_ack && setup_base |=> (phase == 3'h1) [*2]; endproperty
  a_setup2: assert property (p_setup2) else $error("setup too short");
  property p_acc1; $rose(phase == 3'h4) && unit_div == 4'h0 && access_len == 5'h00 |=> phase != 3'h4; endproperty
  a_acc1: assert property (p_acc1) else $error("access not one unit");
  // zero-length phases must be skipped entirely
  property p_skip;
    (phase != 3'h2 || cmd_delay != 2'h0) && (phase != 3'h3 || wr_setup) && (phase != 3'h6 || hold_len != 2'h0);
  endproperty
  a_skip: assert property (p_skip) else $error("empty phase entered");
  property p_noready; !ready_en |-> phase != 3'h5; endproperty
  a_noready: assert property (p_noready) else $error("wait without ready");
  property p_rdy_exit;
    $past(phase) == 3'h5 && phase != 3'h5 && !ready_async |-> $past(ready_in) != $past(ready_active_low);
  endproperty
  a_rdy_exit: assert property (p_rdy_exit) else $error("wait left without ready");
  property p_oe; bus_reference_clock_oe == (bus_reference_clock_sel_sys && bus_reference_clock_hs_en); endproperty
  a_oe: assert property (p_oe) else $error("clock out enable wrong");
  c_wait: cover property (phase == 3'h5);
  c_wr: cover property (phase == 3'h3 ##1 phase == 3'h4);
  c_done: cover property (cycle_done);
endmodule

// File: test/ebseq_ready_model.sv
/* external module answering stretched accesses after a set wait.
   assumes phase shows when the sequencer waits for ready. */
`timescale 1ns/1ps
module ebseq_ready_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] phase,
  input  wire logic       ready_active_low,
  input  wire logic [7:0] delay,
  output logic            ready_in
);
  logic [7:0] cnt_r;
  logic       rdy_r;
  // ready is set only during the wait and drops one clock after it, so it never leaks into the next cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
      rdy_r <= 1'h0;
    end else begin
      cnt_r <= (phase == 3'h5) ? cnt_r + 8'h01 : 8'h00;
      rdy_r <= phase == 3'h5 && cnt_r >= delay;
    end
  end
  assign ready_in = rdy_r ^ ready_active_low;
endmodule

// File: test/tb_ext_bus_cycle_phase_sequencer.sv
/* bench for the bus cycle sequencer: phase lengths, ready waits, clock out.
   assumes the ready model on ready_in and the monitor bound below. */
`timescale 1ns/1ps
module tb_ext_bus_cycle_phase_sequencer;
  logic       ref_clk = 1'h0, rstn = 1'h0, clk_en = 1'h1, start = 1'h0, window_changed = 1'h0;
  logic       setup_base = 1'h0, wr_setup = 1'h0, ready_en = 1'h0, ready_async = 1'h0;
  logic       ready_active_low = 1'h0, bus_reference_clock_sel_sys = 1'h0, bus_reference_clock_hs_en = 1'h0;
  logic [3:0] unit_div = 4'h0;
  logic [1:0] setup_ext = 2'h0, cmd_delay = 2'h0, hold_len = 2'h0;
  logic [4:0] access_len = 5'h00;
  logic       ready_in, start_ack, busy, cycle_done, bus_reference_clock, bus_reference_clock_oe;
  logic [2:0] phase;
  int         n_errors = 0, checks = 0, cycles = 0, n0, n1, cnt[8];

  ebseq_core DUT (.ref_clk, .rstn, .clk_en, .start, .window_changed, .unit_div, .setup_base, .setup_ext,
    .cmd_delay, .wr_setup, .access_len, .hold_len, .ready_en, .ready_async, .ready_active_low, .ready_in,
    .bus_reference_clock_sel_sys, .bus_reference_clock_hs_en, .start_ack, .busy, .phase, .cycle_done, .bus_reference_clock,
    .bus_reference_clock_oe);
  ebseq_ready_model u_rdy (.ref_clk, .rstn, .phase, .ready_active_low, .delay(8'h01), .ready_in);

  // clock and hang guard; no run needs more than a few hundred cycles
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // four-state arguments so an unknown result cannot pass as zero
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // one bus cycle, clocks per phase counted at falling edges
  task automatic run();
    cnt = '{default: 0};
    start = 1'h1;
    do @(negedge ref_clk); while (busy !== 1'h1);
    start = 1'h0;
    while (busy === 1'h1) begin
      cnt[phase]++;
      @(negedge ref_clk);
    end
    chkb(cycle_done, 1'h1);
    @(negedge ref_clk);
    chkb(cycle_done, 1'h0);
  endtask

  // clock enable low mid-cycle holds phase and prescaler, then a reset aborts a cycle
  task automatic freeze();
    int n;
    n = 0;
    access_len = 5'h03;
    start = 1'h1;
    @(negedge ref_clk);
    start = 1'h0;
    clk_en = 1'h0;
    repeat (4) @(negedge ref_clk);
    chk(phase, ebseq_pkg::ADDR_SETUP);
    clk_en = 1'h1;
    while (busy === 1'h1) begin
      n++;
      @(negedge ref_clk);
    end
    chk(n, 5);
    chkb(cycle_done, 1'h1);
    start = 1'h1;
    @(negedge ref_clk);
    start = 1'h0;
    rstn = 1'h0;
    #1 chk(phase, ebseq_pkg::IDLE);
    chkb(cycle_done, 1'h0);
    @(negedge ref_clk) rstn = 1'h1;
  endtask

  task automatic timed(input logic [3:0] d, input logic b, input logic [1:0] e, input logic w,
                       input logic [1:0] c, input logic s, input logic [4:0] a, input logic [1:0] h);
    {unit_div, setup_base, setup_ext, window_changed, cmd_delay, wr_setup, access_len, hold_len} =
      {d, b, e, w, c, s, a, h};
    run();
    chk(cnt[1], (1 + b + (w ? e : 0)) * (d + 1));
    chk(cnt[2], c * (d + 1));
    chk(cnt[3], s * (d + 1));
    chk(cnt[4], (a + 1) * (d + 1));
    chk(cnt[6], h * (d + 1));
    chk(cnt[5], 0);
  endtask

  task automatic rwait(input logic as, input logic lo, output int n);
    ready_en = 1'h1;
    ready_async = as;
    ready_active_low = lo;
    run();
    n = cnt[5];
    ready_en = 1'h0;
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'h1;
    timed(4'h1, 1'h0, 2'h1, 1'h1, 2'h2, 1'h1, 5'h00, 2'h2);
    timed(4'h2, 1'h1, 2'h2, 1'h0, 2'h1, 1'h0, 5'h05, 2'h1);
    timed(4'h0, 1'h1, 2'h3, 1'h1, 2'h3, 1'h1, 5'h1F, 2'h3);
    timed(4'h0, 1'h0, 2'h0, 1'h0, 2'h0, 1'h0, 5'h00, 2'h0);
    for (int lo = 0; lo < 2; lo++) begin
      rwait(1'h0, lo[0], n0);
      chk(int'(n0 >= 1 && n0 <= 5), 1);
      rwait(1'h1, lo[0], n1);
      chk(int'(n1 > n0), 1);
    end
    freeze();
    bus_reference_clock_sel_sys = 1'h1;
    #1 chkb(bus_reference_clock_oe, 1'h0);
    @(negedge ref_clk) bus_reference_clock_hs_en = 1'h1;
    @(posedge ref_clk) #1 chkb(bus_reference_clock, 1'h1);
    @(negedge ref_clk) #1 chkb(bus_reference_clock, 1'h0);
    test_done();
  end
endmodule

bind ebseq_core ebseq_monitor u_mon (.ref_clk, .rstn, .clk_en, .start, .unit_div, .setup_base, .cmd_delay,
  .wr_setup, .access_len, .hold_len, .ready_en, .ready_async, .ready_active_low, .ready_in, .bus_reference_clock_sel_sys,
  .bus_reference_clock_hs_en, .start_ack, .busy, .phase, .cycle_done, .bus_reference_clock_oe);
